/* core/storage_drain_and_isolation_ctrl.sv */
// drain sequencing and isolation switch control of the protection controller
// assumes a serial front end delivers byte register strobes on this clock,
// and that rail comparators and the drain pin arrive asynchronously
module storage_drain_and_isolation_ctrl #(
   parameter int unsigned INTERVAL_CYCLES = drain_iso_pkg::INTERVAL_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic vin_uv,
   input wire logic system_rail_uv,
   input wire logic storage_rail_uv,
   input wire logic sink_current_low,
   input wire logic switch_vds_near_zero,
   input wire logic switch_overcurrent,
   input wire logic input_power_fail,
   input wire logic drain_pin_n,
   output logic efuse_on,
   output logic supplement_buck_on,
   output logic boost_on,
   output logic isolation_switch_en,
   output logic isolation_switch_soft_start,
   output logic isolation_switch_full_limit,
   output logic [2:0] soft_start_current_code,
   output logic storage_rail_sink_on,
   output logic system_rail_sink_on,
   output logic supplement_disabled,
   output logic in_reset_state,
   output logic host_alert_n
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic sink_enable;
      logic single_retry;
      logic manual_switch;
      logic [drain_iso_pkg::SS_CODE_W-1:0] ss_code;
      logic switch_on;
      logic full_drain;
      logic pin_drain;
      logic forced;
      logic drain_done;
      logic node_uv;
      logic sink_active;
      logic drain_forced;
      drain_iso_pkg::main_state_t main_state;
      drain_iso_pkg::switch_state_t sw_state;
      logic [7:0] rdata;
   } ctrl_state_t;

   ctrl_state_t s;
   ctrl_state_t next_s;
   logic [drain_iso_pkg::NUM_INPUTS-1:0] raw_in;
   logic [drain_iso_pkg::NUM_INPUTS-1:0] mon;
   logic drain_req;
   logic drain_exit;
   logic [7:0] rd_value;
   logic wr_rail;
   logic wr_cfg;
   logic wr_ctrl;

   interval_timer_if tif ();

   // ----------------------------------------
   // input synchronisation and interval timer
   // ----------------------------------------
   assign raw_in[drain_iso_pkg::IN_VIN_UV] = vin_uv;
   assign raw_in[drain_iso_pkg::IN_SYS_UV] = system_rail_uv;
   assign raw_in[drain_iso_pkg::IN_STOR_UV] = storage_rail_uv;
   assign raw_in[drain_iso_pkg::IN_SINK_LOW] = sink_current_low;
   assign raw_in[drain_iso_pkg::IN_VDS_ZERO] = switch_vds_near_zero;
   assign raw_in[drain_iso_pkg::IN_OVERCURRENT] = switch_overcurrent;
   assign raw_in[drain_iso_pkg::IN_POWER_FAIL] = input_power_fail;
   assign raw_in[drain_iso_pkg::IN_GPIO_N] = drain_pin_n;

   monitor_sync #(
      .W(drain_iso_pkg::NUM_INPUTS),
      .INIT(drain_iso_pkg::SYNC_INIT)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(raw_in),
      .sync_out(mon)
   );

   interval_timer #(
      .CYCLES(INTERVAL_CYCLES)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .tif(tif)
   );

   // ----------------------------------------
   // request and exit decode
   // ----------------------------------------
   // drain start sources
   assign drain_req = s.full_drain | s.forced
      | (s.pin_drain & ~mon[drain_iso_pkg::IN_GPIO_N]);

   always_comb begin
      if (s.drain_forced) begin
         drain_exit = mon[drain_iso_pkg::IN_SYS_UV] & mon[drain_iso_pkg::IN_STOR_UV]
            & mon[drain_iso_pkg::IN_VIN_UV];
      end else if (s.sink_active) begin
         drain_exit = mon[drain_iso_pkg::IN_SYS_UV] & mon[drain_iso_pkg::IN_STOR_UV]
            & mon[drain_iso_pkg::IN_SINK_LOW];
      end else begin
         drain_exit = mon[drain_iso_pkg::IN_SYS_UV];
      end
   end

   assign wr_rail = reg_wr && (reg_addr == drain_iso_pkg::ADDR_RAIL_DRAIN_CONFIG);
   assign wr_cfg = reg_wr && (reg_addr == drain_iso_pkg::ADDR_ISOLATION_SWITCH_CONFIG);
   assign wr_ctrl = reg_wr && (reg_addr == drain_iso_pkg::ADDR_DRAIN_AND_SWITCH_CONTROL);

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // unmapped offsets and reserved bits read as zero
   always_comb begin
      rd_value = 8'h00;
      case (reg_addr)
         drain_iso_pkg::ADDR_RAIL_DRAIN_CONFIG: begin
            rd_value[drain_iso_pkg::BIT_SINK_ENABLE] = s.sink_enable;
         end
         drain_iso_pkg::ADDR_ISOLATION_SWITCH_CONFIG: begin
            rd_value[drain_iso_pkg::BIT_SINGLE_RETRY] = s.single_retry;
            rd_value[drain_iso_pkg::BIT_MANUAL_SWITCH] = s.manual_switch;
            rd_value[drain_iso_pkg::SS_CODE_LSB +: drain_iso_pkg::SS_CODE_W] = s.ss_code;
         end
         drain_iso_pkg::ADDR_DRAIN_AND_SWITCH_CONTROL: begin
            rd_value[drain_iso_pkg::BIT_SWITCH_ON] = s.switch_on;
            rd_value[drain_iso_pkg::BIT_FULL_DRAIN] = s.full_drain;
            rd_value[drain_iso_pkg::BIT_PIN_DRAIN] = s.pin_drain;
            rd_value[drain_iso_pkg::BIT_FORCED] = s.forced;
            rd_value[drain_iso_pkg::BIT_DRAIN_DONE] = s.drain_done;
            rd_value[drain_iso_pkg::BIT_NODE_UV] = s.node_uv;
         end
         default: begin
            rd_value = 8'h00;
         end
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_s = s;
      tif.start = 1'b0;
      if (reg_rd) begin
         next_s.rdata = rd_value;
      end

      // configuration writes
      if (wr_rail) begin
         next_s.sink_enable = reg_wdata[drain_iso_pkg::BIT_SINK_ENABLE];
      end
      if (wr_cfg) begin
         next_s.single_retry = reg_wdata[drain_iso_pkg::BIT_SINGLE_RETRY];
         next_s.manual_switch = reg_wdata[drain_iso_pkg::BIT_MANUAL_SWITCH];
         next_s.ss_code = reg_wdata[drain_iso_pkg::SS_CODE_LSB +: drain_iso_pkg::SS_CODE_W];
      end
      // flags clear on write of one; hardware sets below win the same cycle
      if (wr_ctrl) begin
         next_s.switch_on = reg_wdata[drain_iso_pkg::BIT_SWITCH_ON];
         next_s.pin_drain = reg_wdata[drain_iso_pkg::BIT_PIN_DRAIN];
         if (reg_wdata[drain_iso_pkg::BIT_DRAIN_DONE]) begin
            next_s.drain_done = 1'b0;
         end
         if (reg_wdata[drain_iso_pkg::BIT_NODE_UV]) begin
            next_s.node_uv = 1'b0;
         end
      end

      // main sequencer
      case (s.main_state)
         drain_iso_pkg::M_POR: begin
            // undervoltage sink stops at low current
            if (mon[drain_iso_pkg::IN_SINK_LOW]) begin
               next_s.sink_active = 1'b0;
            end
            if (drain_req) begin
               next_s.main_state = drain_iso_pkg::M_DRAIN_BUCK_OFF;
            end else if (!mon[drain_iso_pkg::IN_VIN_UV]) begin
               next_s.sink_active = 1'b0;
               next_s.main_state = drain_iso_pkg::M_RUN;
            end
         end
         drain_iso_pkg::M_RUN: begin
            if (drain_req) begin
               next_s.main_state = drain_iso_pkg::M_DRAIN_BUCK_OFF;
            end else if (mon[drain_iso_pkg::IN_VIN_UV]) begin
               next_s.sink_active = s.sink_enable;
               next_s.main_state = drain_iso_pkg::M_POR;
            end
         end
         drain_iso_pkg::M_DRAIN_BUCK_OFF: begin
            next_s.sink_active = s.sink_enable;
            next_s.drain_forced = s.forced;
            next_s.drain_done = 1'b0;
            next_s.main_state = drain_iso_pkg::M_DRAIN_ISOLATE;
         end
         drain_iso_pkg::M_DRAIN_ISOLATE: begin
            // boost and switch off before sinking
            next_s.main_state = drain_iso_pkg::M_DRAIN_SINK;
         end
         drain_iso_pkg::M_DRAIN_SINK: begin
            // completion seen on low sink current
            if (s.sink_active && mon[drain_iso_pkg::IN_SINK_LOW]) begin
               next_s.drain_done = 1'b1;
            end
            if (drain_exit) begin
               next_s.drain_done = 1'b1;
               next_s.full_drain = 1'b0;
               next_s.forced = 1'b0;
               next_s.sink_active = 1'b0;
               next_s.drain_forced = 1'b0;
               next_s.main_state = drain_iso_pkg::M_POR;
            end
         end
         default: begin
            next_s.main_state = drain_iso_pkg::M_POR;
         end
      endcase

      // isolation switch sequencer, active only in normal run
      if (s.main_state != drain_iso_pkg::M_RUN) begin
         next_s.sw_state = drain_iso_pkg::S_OFF;
      end else begin
         case (s.sw_state)
            drain_iso_pkg::S_OFF: begin
               if (!s.manual_switch || s.switch_on) begin
                  next_s.sw_state = drain_iso_pkg::S_SOFT;
               end
            end
            drain_iso_pkg::S_SOFT: begin
               // constant current until near zero drop
               if (mon[drain_iso_pkg::IN_OVERCURRENT]) begin
                  next_s.node_uv = 1'b1;
                  next_s.sw_state = drain_iso_pkg::S_HICCUP;
               end else if (mon[drain_iso_pkg::IN_VDS_ZERO]) begin
                  next_s.sw_state = drain_iso_pkg::S_ON;
               end else if (tif.expired) begin
                  if (s.single_retry) begin
                     next_s.sw_state = drain_iso_pkg::S_HALT;
                  end else begin
                     next_s.sw_state = drain_iso_pkg::S_HICCUP;
                  end
               end
            end
            drain_iso_pkg::S_ON: begin
               if (mon[drain_iso_pkg::IN_OVERCURRENT]) begin
                  next_s.node_uv = 1'b1;
                  next_s.sw_state = drain_iso_pkg::S_HICCUP;
               end else if (mon[drain_iso_pkg::IN_POWER_FAIL]) begin
                  next_s.sw_state = drain_iso_pkg::S_SUPPL;
               end
            end
            drain_iso_pkg::S_SUPPL: begin
               if (!mon[drain_iso_pkg::IN_POWER_FAIL]) begin
                  next_s.sw_state = drain_iso_pkg::S_ON;
               end
            end
            drain_iso_pkg::S_HICCUP: begin
               if (tif.expired) begin
                  next_s.sw_state = drain_iso_pkg::S_SOFT;
               end
            end
            drain_iso_pkg::S_HALT: begin
               next_s.sw_state = drain_iso_pkg::S_HALT;
            end
            default: begin
               next_s.sw_state = drain_iso_pkg::S_OFF;
            end
         endcase
         // manual off overrides, halt stays put
         if (s.manual_switch && !s.switch_on && s.sw_state != drain_iso_pkg::S_HALT) begin
            next_s.sw_state = drain_iso_pkg::S_OFF;
         end
      end

      if (next_s.sw_state != s.sw_state
          && (next_s.sw_state == drain_iso_pkg::S_SOFT
              || next_s.sw_state == drain_iso_pkg::S_HICCUP)) begin
         tif.start = 1'b1;
      end

      // requests set last so a write never loses to the hardware clear
      if (wr_ctrl) begin
         if (reg_wdata[drain_iso_pkg::BIT_FULL_DRAIN]) begin
            next_s.full_drain = 1'b1;
         end
         if (reg_wdata[drain_iso_pkg::BIT_FORCED]) begin
            next_s.forced = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s.sink_enable <= drain_iso_pkg::RST_RAIL_DRAIN_CONFIG[drain_iso_pkg::BIT_SINK_ENABLE];
         s.single_retry <=
            drain_iso_pkg::RST_ISOLATION_SWITCH_CONFIG[drain_iso_pkg::BIT_SINGLE_RETRY];
         s.manual_switch <=
            drain_iso_pkg::RST_ISOLATION_SWITCH_CONFIG[drain_iso_pkg::BIT_MANUAL_SWITCH];
         s.ss_code <= drain_iso_pkg::RST_ISOLATION_SWITCH_CONFIG[
            drain_iso_pkg::SS_CODE_LSB +: drain_iso_pkg::SS_CODE_W];
         s.switch_on <=
            drain_iso_pkg::RST_DRAIN_AND_SWITCH_CONTROL[drain_iso_pkg::BIT_SWITCH_ON];
         s.full_drain <=
            drain_iso_pkg::RST_DRAIN_AND_SWITCH_CONTROL[drain_iso_pkg::BIT_FULL_DRAIN];
         s.pin_drain <=
            drain_iso_pkg::RST_DRAIN_AND_SWITCH_CONTROL[drain_iso_pkg::BIT_PIN_DRAIN];
         s.forced <= drain_iso_pkg::RST_DRAIN_AND_SWITCH_CONTROL[drain_iso_pkg::BIT_FORCED];
         s.drain_done <=
            drain_iso_pkg::RST_DRAIN_AND_SWITCH_CONTROL[drain_iso_pkg::BIT_DRAIN_DONE];
         s.node_uv <= drain_iso_pkg::RST_DRAIN_AND_SWITCH_CONTROL[drain_iso_pkg::BIT_NODE_UV];
         s.sink_active <= 1'b0;
         s.drain_forced <= 1'b0;
         s.main_state <= drain_iso_pkg::M_POR;
         s.sw_state <= drain_iso_pkg::S_OFF;
         s.rdata <= drain_iso_pkg::RST_READ_DATA;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // output decode
   // ----------------------------------------
   // eFuse follows run state only, so hiccup keeps the system up
   assign efuse_on = (s.main_state == drain_iso_pkg::M_RUN);
   // storage buck feeds the system rail
   assign supplement_buck_on = efuse_on && (s.sw_state == drain_iso_pkg::S_SUPPL);
   assign isolation_switch_en = efuse_on && (s.sw_state == drain_iso_pkg::S_SOFT
      || s.sw_state == drain_iso_pkg::S_ON || s.sw_state == drain_iso_pkg::S_SUPPL);
   // soft start current and full limit
   assign isolation_switch_soft_start = efuse_on && (s.sw_state == drain_iso_pkg::S_SOFT);
   assign isolation_switch_full_limit = efuse_on && (s.sw_state == drain_iso_pkg::S_ON
      || s.sw_state == drain_iso_pkg::S_SUPPL);
   // boost only with switch fully on
   assign boost_on = efuse_on && (s.sw_state == drain_iso_pkg::S_ON);
   assign soft_start_current_code = s.ss_code;
   // rail sinks in reset or drain
   assign storage_rail_sink_on = s.sink_active && (s.main_state == drain_iso_pkg::M_POR
      || s.main_state == drain_iso_pkg::M_DRAIN_SINK);
   assign system_rail_sink_on = storage_rail_sink_on;
   assign supplement_disabled = efuse_on && (s.sw_state == drain_iso_pkg::S_HICCUP
      || s.sw_state == drain_iso_pkg::S_HALT);
   assign in_reset_state = !efuse_on;
   assign host_alert_n = ~s.node_uv;
   assign reg_rdata = s.rdata;

endmodule

/* core/drain_iso_pkg.sv */
// constants, register map and state encodings for the drain and isolation control
// assumes an external serial front end turns host transfers into byte register strobes
package drain_iso_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_RAIL_DRAIN_CONFIG = 8'h2a;
   localparam logic [7:0] ADDR_ISOLATION_SWITCH_CONFIG = 8'h34;
   localparam logic [7:0] ADDR_DRAIN_AND_SWITCH_CONTROL = 8'heb;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_SINK_ENABLE = 4;
   localparam int BIT_SINGLE_RETRY = 0;
   localparam int BIT_MANUAL_SWITCH = 1;
   localparam int SS_CODE_LSB = 2;
   localparam int SS_CODE_W = 3;
   localparam int BIT_SWITCH_ON = 0;
   localparam int BIT_FULL_DRAIN = 1;
   localparam int BIT_PIN_DRAIN = 2;
   localparam int BIT_FORCED = 3;
   localparam int BIT_DRAIN_DONE = 4;
   localparam int BIT_NODE_UV = 5;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_RAIL_DRAIN_CONFIG = 8'h00;
   localparam logic [7:0] RST_ISOLATION_SWITCH_CONFIG = 8'h00;
   localparam logic [7:0] RST_DRAIN_AND_SWITCH_CONTROL = 8'h00;
   localparam logic [7:0] RST_READ_DATA = 8'h00;

   // ----------------------------------------
   // monitor input positions and their idle levels
   // ----------------------------------------
   localparam int IN_VIN_UV = 0;
   localparam int IN_SYS_UV = 1;
   localparam int IN_STOR_UV = 2;
   localparam int IN_SINK_LOW = 3;
   localparam int IN_VDS_ZERO = 4;
   localparam int IN_OVERCURRENT = 5;
   localparam int IN_POWER_FAIL = 6;
   localparam int IN_GPIO_N = 7;
   localparam int NUM_INPUTS = 8;
   localparam logic [7:0] SYNC_INIT = 8'h87;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int INTERVAL_MS = 250;
   localparam int CLK_MHZ = 250;
   localparam int INTERVAL_CYCLES = INTERVAL_MS * 1000 * CLK_MHZ;

   // ----------------------------------------
   // state encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      M_POR = 3'h0,
      M_RUN = 3'h1,
      M_DRAIN_BUCK_OFF = 3'h2,
      M_DRAIN_ISOLATE = 3'h3,
      M_DRAIN_SINK = 3'h4
   } main_state_t;

   typedef enum logic [2:0] {
      S_OFF = 3'h0,
      S_SOFT = 3'h1,
      S_ON = 3'h2,
      S_SUPPL = 3'h3,
      S_HICCUP = 3'h4,
      S_HALT = 3'h5
   } switch_state_t;

endpackage

/* core/interval_timer_if.sv */
// start and expiry of the shared interval timer
// assumes the controller and the timer share one clock
interface interval_timer_if;
   logic start;
   logic expired;
   modport ctrl (output start, input expired);
   modport timer (input start, output expired);
endinterface

/* core/monitor_sync.sv */
// three-stage synchroniser for comparator and pin inputs
// assumes inputs are asynchronous levels; an output moves once stages two and three agree
module monitor_sync #(
   parameter int W = drain_iso_pkg::NUM_INPUTS,
   parameter logic [W-1:0] INIT = drain_iso_pkg::SYNC_INIT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;
   logic [W-1:0] agree;

   // the first stage feeds only the second; filtering looks at stages two and three
   always_comb begin
      agree = ~(s.s2 ^ s.s3);
      next_s = s;
      next_s.s1 = async_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.out = (s.s3 & agree) | (s.out & ~agree);
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= {INIT, INIT, INIT, INIT};
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.out;

endmodule

/* core/interval_timer.sv */
// one-shot interval timer, restarted by a start pulse
// assumes start is a single-cycle pulse from logic on the same clock
module interval_timer #(
   parameter int unsigned CYCLES = drain_iso_pkg::INTERVAL_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   interval_timer_if.timer tif
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] count;
      logic running;
      logic expired;
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;

   // a start always wins, so a stale expiry never leaks into a new interval
   always_comb begin
      next_s = s;
      if (tif.start) begin
         next_s.count = '0;
         next_s.running = 1'b1;
         next_s.expired = 1'b0;
      end else if (s.running) begin
         if (s.count == LAST) begin
            next_s.running = 1'b0;
            next_s.expired = 1'b1;
         end else begin
            next_s.count = s.count + W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tif.expired = s.expired;

endmodule

/* dv/drain_iso_properties.sv */
// port assertions for the drain and isolation control
// assumes it is bound to the top module; one clock domain
module drain_iso_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic efuse_on,
   input wire logic supplement_buck_on,
   input wire logic boost_on,
   input wire logic isolation_switch_en,
   input wire logic isolation_switch_soft_start,
   input wire logic isolation_switch_full_limit,
   input wire logic [2:0] soft_start_current_code,
   input wire logic storage_rail_sink_on,
   input wire logic system_rail_sink_on,
   input wire logic supplement_disabled,
   input wire logic in_reset_state,
   input wire logic host_alert_n
);
   // ---------------------------------
   // relations between outputs
   // ---------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_boost_needs_switch: assert property (boost_on |-> isolation_switch_full_limit)
      else $error("boost on without switch on");
   a_sinks_paired: assert property (storage_rail_sink_on == system_rail_sink_on)
      else $error("rail sinks differ");
   a_sink_isolated: assert property (storage_rail_sink_on |-> !efuse_on && !boost_on
      && !isolation_switch_en && !supplement_buck_on) else $error("sink with paths on");
   a_reset_flag: assert property (in_reset_state != efuse_on)
      else $error("reset flag wrong");
   a_buck_in_suppl: assert property (supplement_buck_on |-> efuse_on
      && isolation_switch_full_limit) else $error("buck on outside supplement");
   a_hiccup_efuse: assert property (supplement_disabled |-> efuse_on
      && !isolation_switch_en) else $error("hiccup state wrong");
   a_trip_alert: assert property ($fell(host_alert_n) |-> supplement_disabled)
      else $error("alert without trip");
   a_soft_mode: assert property (isolation_switch_soft_start |-> isolation_switch_en
      && !isolation_switch_full_limit) else $error("soft start mode wrong");
   a_code_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h34
      |=> reg_rdata[4:2] == soft_start_current_code) else $error("code readback wrong");
endmodule
bind storage_drain_and_isolation_ctrl drain_iso_properties u_props (.*);

/* dv/drain_host_model.sv */
// host side model: register strobes and the drain pin
// assumes strobes are sampled on the rising edge, so all changes happen on the falling one
module drain_host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic drain_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: no strobe, pin released high
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, drain_pin_n} = 19'h00001;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // data is taken on the falling edge, half a cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic pin(input logic v);
      @(negedge clk);
      drain_pin_n = v;
   endtask
endmodule

/* dv/storage_drain_and_isolation_ctrl_test.sv */
// self-checking bench for the drain and isolation control
// assumes a short interval parameter so hiccup timing stays brief
module storage_drain_and_isolation_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IV = 20;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic clk, rstn, reg_wr, reg_rd, drain_pin_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic [2:0] soft_start_current_code;
   logic efuse_on, supplement_buck_on, boost_on, isolation_switch_en, host_alert_n;
   logic isolation_switch_soft_start, isolation_switch_full_limit, storage_rail_sink_on;
   logic system_rail_sink_on, supplement_disabled, in_reset_state;
   logic vin_uv = 1'b1, system_rail_uv = 1'b1, storage_rail_uv = 1'b1;
   logic sink_current_low = 1'b0, switch_vds_near_zero = 1'b0;
   logic switch_overcurrent = 1'b0, input_power_fail = 1'b0;
   int miscompares = 0, checks_done = 0, n;
   // reserved bits read back as zero, unmapped place reads zero
   row_t rows[4] = '{'{8'h2a, 8'hff, 8'h10}, '{8'h34, 8'hff, 8'h1f},
                     '{8'h55, 8'hff, 8'h00}, '{8'h34, 8'h1c, 8'h1c}};
   storage_drain_and_isolation_ctrl #(.INTERVAL_CYCLES(IV)) u_dut (.*);
   drain_host_model u_host (.*);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask
   // bounded wait; running out is a mismatch and ends the run
   task automatic wait_for(ref logic s, input logic v);
      for (n = 0; n < 200 && s !== v; n++) @(negedge clk);
      chk("wait", 8'(v), 8'(s));
      if (s !== v) report_and_stop();
   endtask
   initial begin
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      chk("efuse", 8'h00, 8'(efuse_on));
      foreach (rows[i]) begin
         u_host.wr(rows[i].a, rows[i].d);
         u_host.rd(rows[i].a, rd_val);
         chk("reg", rows[i].e, rd_val);
      end
      {vin_uv, system_rail_uv, storage_rail_uv} = 3'h0;
      wait_for(efuse_on, 1'b1);
      wait_for(isolation_switch_soft_start, 1'b1);
      switch_vds_near_zero = 1'b1;
      wait_for(boost_on, 1'b1);
      input_power_fail = 1'b1;
      wait_for(supplement_buck_on, 1'b1);
      input_power_fail = 1'b0;
      wait_for(boost_on, 1'b1);
      switch_overcurrent = 1'b1;
      wait_for(supplement_disabled, 1'b1);
      chk("alert", 8'h00, 8'(host_alert_n));
      chk("efuse", 8'h01, 8'(efuse_on));
      {switch_overcurrent, switch_vds_near_zero} = 2'h0;
      for (n = 0; n < 100 && isolation_switch_soft_start !== 1'b1; n++) @(negedge clk);
      chk("off time", 8'h01, 8'(n >= IV - 1 && n <= IV + 2));
      wait_for(supplement_disabled, 1'b1);
      u_host.wr(8'h34, 8'h1d);
      wait_for(isolation_switch_soft_start, 1'b1);
      repeat (3 * IV) @(negedge clk);
      chk("halted", 8'h01, 8'(supplement_disabled));
      u_host.wr(8'heb, 8'h20);
      chk("alert", 8'h01, 8'(host_alert_n));
      u_host.wr(8'heb, 8'h02);
      wait_for(storage_rail_sink_on, 1'b1);
      chk("efuse", 8'h00, 8'(efuse_on));
      {system_rail_uv, storage_rail_uv, sink_current_low} = 3'h7;
      wait_for(storage_rail_sink_on, 1'b0);
      u_host.rd(8'heb, rd_val);
      chk("status", 8'h10, rd_val);
      wait_for(efuse_on, 1'b1);
      {system_rail_uv, storage_rail_uv, sink_current_low} = 3'h0;
      u_host.wr(8'heb, 8'h04);
      u_host.pin(1'b0);
      wait_for(storage_rail_sink_on, 1'b1);
      u_host.pin(1'b1);
      {system_rail_uv, storage_rail_uv, sink_current_low} = 3'h7;
      wait_for(efuse_on, 1'b1);
      u_host.wr(8'h34, 8'h1e);
      wait_for(isolation_switch_en, 1'b0);
      repeat (2 * IV) @(negedge clk);
      chk("manual off", 8'h00, 8'(isolation_switch_en));
      u_host.wr(8'heb, 8'h01);
      wait_for(isolation_switch_soft_start, 1'b1);
      u_host.wr(8'h2a, 8'h00);
      u_host.wr(8'heb, 8'h08);
      wait_for(efuse_on, 1'b0);
      repeat (2 * IV) @(negedge clk);
      chk("forced hold", 8'h00, 8'(efuse_on));
      chk("no sink", 8'h00, 8'(storage_rail_sink_on));
      vin_uv = 1'b1;
      repeat (8) @(negedge clk);
      u_host.rd(8'heb, rd_val);
      chk("forced clear", 8'h10, rd_val);
      vin_uv = 1'b0;
      wait_for(efuse_on, 1'b1);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      chk("reset rdata", 8'h00, reg_rdata);
      rstn = 1'b1;
      u_host.rd(8'h34, rd_val);
      chk("reset cfg", 8'h00, rd_val);
      wait_for(efuse_on, 1'b1);
      report_and_stop();
   end
endmodule
